// ==== if_decimator_gain_rssi.sv ====
// Mixer, three-stage decimator, digital gain, VGA DAC code and signal strength
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Complex eighth-rate mixer before three decimators
// - First stage: fourth-order comb, divide twelve
// - Second stage: comb, ratio from config field
// - Third stage FIR divides by five or four
// - Overall ratio 60 or 48 times second ratio
// - Output rate equals clock over overall ratio
// - Digital gain enabled only when field is one
// - Digital gain adds up to 12 dB
// - Reference level zero means manual gain word
// - Gain word top bit switches mixer attenuator
// - Digital gain on: fifteen bits, -12..+12 dB
// - Digital gain off: fourteen bits, 0..12 dB
// - Eight-bit DAC code drives gain control pin
// - Selectable ninefold lower DAC output resistance
// - Strength from first stage, plus gain output when digital gain is on
// - Six-bit strength, sixty means full scale
// - Strength refreshed every 60 clocks with attenuation
// - Larger DAC code raises full scale, attenuates
// - Nonzero reference level selects automatic gain
// - Gain four takes bits below top two
module if_decimator_gain_rssi
   import ifdec_pkg::*;
#(
   parameter int IN_W = 4,
   parameter int M_W = 5
) (
   input wire logic REF_CLK,
   input wire logic RST,
   input wire logic signed [IN_W-1:0] ADC_DATA,
   input wire logic [M_W-1:0] SECOND_STAGE_RATIO,
   input wire logic THIRD_STAGE_SELECT,
   input wire logic DIGITAL_GAIN_ENABLE,
   input wire logic [2:0] GAIN_REFERENCE_LEVEL,
   input wire logic [15:0] MANUAL_GAIN_WORD,
   input wire logic MANUAL_GAIN_WRITE,
   input wire logic FAST_SETTLE,
   output logic signed [OUT_W-1:0] I_OUT,
   output logic signed [OUT_W-1:0] Q_OUT,
   output logic OUT_VALID,
   output logic [5:0] RSSI,
   output logic [7:0] ATTN,
   output logic RSSI_VALID,
   output logic [7:0] GAIN_CONTROL_PIN,
   output logic DAC_LOW_R,
   output logic MIXER_ATTEN,
   output logic AUTO_GAIN_ACTIVE
);
   if (IN_W < 2 || M_W < 1 || ACC_W < IN_W + 8 + 16 + 4 * M_W + 3) begin : g_bad
      $error("Accumulator too narrow for IN_W and M_W");
   end

   function automatic logic signed [7:0] cos_lut(input logic [2:0] p);
      case (p)
         3'h0: cos_lut = 8'sh40;
         3'h1, 3'h7: cos_lut = 8'sh2d;
         3'h3, 3'h5: cos_lut = -8'sh2d;
         3'h4: cos_lut = -8'sh40;
         default: cos_lut = 8'sh00;
      endcase
   endfunction : cos_lut

   function automatic logic [15:0] mag(input logic signed [15:0] v);
      mag = v[15] ? 16'(-v) : 16'(v);
   endfunction : mag

   // Sequencing: mixer phase, stage counters and strobes
   logic [2:0] phase_q, phase_d;
   logic [3:0] c1_q, c1_d;
   logic [M_W-1:0] c2_q, c2_d, m_eff;
   logic [2:0] c3_q, c3_d;
   logic s1, s2, last3;
   logic s1v_q, s2v_q, s3v_q, ov_q;

   always_comb begin
      m_eff = (SECOND_STAGE_RATIO == '0) ? M_W'(1) : SECOND_STAGE_RATIO;
      phase_d = phase_q + 3'h1;
      s1 = (c1_q == FIRST_DECIMATOR_LAST);
      c1_d = s1 ? 4'h0 : c1_q + 4'h1;
      s2 = s1v_q && (c2_q == m_eff - M_W'(1));
      c2_d = c2_q;
      if (s1v_q) begin
         c2_d = s2 ? '0 : c2_q + M_W'(1);
      end
      last3 = (c3_q == (THIRD_STAGE_SELECT ? THIRD_DECIMATOR_LAST_BY4 : THIRD_DECIMATOR_LAST_BY5));
      c3_d = c3_q;
      if (s2v_q) begin
         c3_d = last3 ? 3'h0 : c3_q + 3'h1;
      end
   end

   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         phase_q <= '0;
         c1_q <= '0;
         c2_q <= '0;
         c3_q <= '0;
         s1v_q <= 1'b0;
         s2v_q <= 1'b0;
         s3v_q <= 1'b0;
         ov_q <= 1'b0;
      end else begin
         phase_q <= phase_d;
         c1_q <= c1_d;
         c2_q <= c2_d;
         c3_q <= c3_d;
         s1v_q <= s1;
         s2v_q <= s2;
         s3v_q <= s2v_q && last3;
         ov_q <= s3v_q;
      end
   end

   // Gain control: manual word, DAC code, digital shift
   gain_mode_t mode;
   logic [15:0] word_q, word_d;
   logic [7:0] dac_q, dac_d;
   logic [1:0] g_q, g_d;
   logic atten_q, lowr_q, auto_q;

   always_comb begin
      mode = (GAIN_REFERENCE_LEVEL == 3'h0) ? MODE_MANUAL : MODE_AUTO;
      word_d = word_q;
      if (mode == MODE_MANUAL && MANUAL_GAIN_WRITE) begin
         word_d = MANUAL_GAIN_WORD;
      end
      g_d = 2'h0;
      dac_d = word_q[13:6];
      if (DIGITAL_GAIN_ENABLE) begin
         // lower half of span is digital gain
         if (!word_q[14]) begin
            dac_d = DAC_RST;
            g_d = word_q[13] ? 2'h0 : (word_q[12] ? 2'h1 : DG_SHIFT_MAX);
         end else begin
            dac_d = word_q[13:6];
         end
      end
   end

   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         word_q <= GAIN_WORD_RST;
         dac_q <= DAC_RST;
         g_q <= '0;
         atten_q <= 1'b0;
         lowr_q <= 1'b0;
         auto_q <= 1'b0;
      end else begin
         word_q <= word_d;
         dac_q <= dac_d;
         g_q <= g_d;
         atten_q <= word_q[15];
         lowr_q <= FAST_SETTLE;
         auto_q <= (mode == MODE_AUTO);
      end
   end

   // Per-channel filter chain: I on 0, Q on 1
   logic signed [15:0] s1_top[2];
   logic signed [OUT_W-1:0] dout_q[2];

   for (genvar ch = 0; ch < 2; ch++) begin : g_ch
      acc_t i1_q[4], i1_d[4], k1_q[4], k1_d[4], i2_q[4], i2_d[4], k2_q[4], k2_d[4];
      acc_t s1_q, s1_d, s2_q, s2_d, a3_q, a3_d, s3_q, s3_d;
      logic signed [OUT_W-1:0] dout_d;
      logic signed [IN_W+7:0] prod;
      logic signed [WORD_W+1:0] ext;

      always_comb begin
         acc_t y;
         y = '0;
         prod = ADC_DATA * (ch == 0 ? cos_lut(phase_q) : cos_lut(phase_q + 3'h6));
         i1_d[0] = i1_q[0] + ACC_W'(prod);
         i2_d[0] = i2_q[0] + (s1v_q ? s1_q : '0);
         for (int k = 1; k < 4; k++) begin
            i1_d[k] = i1_q[k] + i1_q[k-1];
            i2_d[k] = s1v_q ? i2_q[k] + i2_q[k-1] : i2_q[k];
         end
         k1_d = k1_q;
         s1_d = s1_q;
         if (s1) begin
            y = i1_q[3];
            for (int k = 0; k < 4; k++) begin
               k1_d[k] = y;
               y = y - k1_q[k];
            end
            s1_d = y;
         end
         k2_d = k2_q;
         s2_d = s2_q;
         if (s2) begin
            y = i2_q[3];
            for (int k = 0; k < 4; k++) begin
               k2_d[k] = y;
               y = y - k2_q[k];
            end
            s2_d = y;
         end
         a3_d = a3_q;
         s3_d = s3_q;
         // boxcar FIR over five or four
         if (s2v_q) begin
            if (last3) begin
               s3_d = a3_q + s2_q;
               a3_d = '0;
            end else begin
               a3_d = a3_q + s2_q;
            end
         end
         // shift up to two, saturates on overflow
         // Part-select is unsigned; restore sign before widening
         ext = (WORD_W + 2)'($signed(s3_q[ACC_W-1 -: WORD_W])) <<< g_q;
         dout_d = dout_q[ch];
         if (s3v_q) begin
            dout_d = ext[WORD_W-1 -: OUT_W];
            if (ext[WORD_W+1:WORD_W-1] != {3{ext[WORD_W+1]}}) begin
               dout_d = ext[WORD_W+1] ? 16'sh8000 : 16'sh7fff;
            end
         end
      end

      always_ff @(posedge REF_CLK or posedge RST) begin
         if (RST) begin
            i1_q <= '{default: '0};
            k1_q <= '{default: '0};
            i2_q <= '{default: '0};
            k2_q <= '{default: '0};
            s1_q <= '0;
            s2_q <= '0;
            a3_q <= '0;
            s3_q <= '0;
            dout_q[ch] <= '0;
         end else begin
            i1_q <= i1_d;
            k1_q <= k1_d;
            i2_q <= i2_d;
            k2_q <= k2_d;
            s1_q <= s1_d;
            s2_q <= s2_d;
            a3_q <= a3_d;
            s3_q <= s3_d;
            dout_q[ch] <= dout_d;
         end
      end
      assign s1_top[ch] = s1_q[ACC_W-1 -: 16];
   end

   // Signal strength: peak estimate per window, scaled to 0..60
   logic [5:0] rc_q, rc_d, rssi_q, rssi_d;
   logic [16:0] pk_q, pk_d, e1, e2;
   logic rv_q;

   always_comb begin
      e1 = 17'(mag(s1_top[0])) + 17'(mag(s1_top[1]));
      e2 = DIGITAL_GAIN_ENABLE ? 17'(mag(dout_q[0])) + 17'(mag(dout_q[1])) : '0;
      pk_d = pk_q;
      if (e1 > pk_d) begin
         pk_d = e1;
      end
      if (e2 > pk_d) begin
         pk_d = e2;
      end
      rssi_d = rssi_q;
      rc_d = rc_q + 6'h1;
      if (rc_q == RSSI_LAST) begin
         rc_d = '0;
         rssi_d = (pk_d[16:11] > RSSI_FULL) ? RSSI_FULL : pk_d[16:11];
         pk_d = '0;
      end
   end

   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         rc_q <= '0;
         pk_q <= '0;
         rssi_q <= '0;
         rv_q <= 1'b0;
      end else begin
         rc_q <= rc_d;
         pk_q <= pk_d;
         rssi_q <= rssi_d;
         rv_q <= (rc_q == RSSI_LAST);
      end
   end

   assign I_OUT = dout_q[0];
   assign Q_OUT = dout_q[1];
   assign OUT_VALID = ov_q;
   assign RSSI = rssi_q;
   assign RSSI_VALID = rv_q;
   assign ATTN = word_q[15:8];
   assign GAIN_CONTROL_PIN = dac_q;
   assign DAC_LOW_R = lowr_q;
   assign MIXER_ATTEN = atten_q;
   assign AUTO_GAIN_ACTIVE = auto_q;

   // Checking helpers: gaps between output strobes
   logic [15:0] ogap_q, rgap_q;
   logic oseen_q, rseen_q, chg_q;
   logic [15:0] ratio;
   always_comb ratio = 16'(THIRD_STAGE_SELECT ? RATIO_K1 : RATIO_K0) * 16'(m_eff);
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         ogap_q <= '0;
         rgap_q <= '0;
         oseen_q <= 1'b0;
         rseen_q <= 1'b0;
         chg_q <= 1'b1;
      end else begin
         ogap_q <= ov_q ? 16'h0 : ogap_q + 16'h1;
         rgap_q <= rv_q ? 16'h0 : rgap_q + 16'h1;
         oseen_q <= oseen_q | ov_q;
         rseen_q <= rseen_q | rv_q;
         chg_q <= ov_q ? 1'b0 : chg_q | (ratio != $past(ratio));
      end
   end

   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (RST);

   a_first_decimator_period: assert property (s1 |=> !s1 ##11 s1)
      else $error("First stage strobe not every twelve clocks");
   a_out_rate: assert property (OUT_VALID && oseen_q && !chg_q |-> ogap_q == ratio - 16'h1)
      else $error("Output spacing differs from overall ratio");
   a_out_hold: assert property (!OUT_VALID |-> $stable(I_OUT) && $stable(Q_OUT))
      else $error("Output sample changed without valid pulse");
   a_rssi_period: assert property (RSSI_VALID && rseen_q |-> rgap_q == 16'(RSSI_LAST))
      else $error("Strength not refreshed every sixty clocks");
   a_rssi_limit: assert property (RSSI <= RSSI_FULL)
      else $error("Strength above full scale");
   a_atten_msb: assert property (!auto_q && MANUAL_GAIN_WRITE && mode == MODE_MANUAL
      |=> ##1 MIXER_ATTEN == $past(MANUAL_GAIN_WORD[15], 2))
      else $error("Attenuator does not follow top bit");
   a_manual_take: assert property (mode == MODE_MANUAL && MANUAL_GAIN_WRITE
      |=> word_q == $past(MANUAL_GAIN_WORD))
      else $error("Manual word not taken");
   a_auto_hold: assert property (mode == MODE_AUTO |=> $stable(word_q))
      else $error("Gain word changed in automatic mode");
   a_bypass_dac: assert property (!DIGITAL_GAIN_ENABLE |=> GAIN_CONTROL_PIN == $past(word_q[13:6]))
      else $error("Bypassed DAC code not from fourteen bits");
   a_dg_nodac: assert property (DIGITAL_GAIN_ENABLE && !word_q[14]
      |=> GAIN_CONTROL_PIN == DAC_RST && g_q != 2'h3)
      else $error("Digital region moved the analog DAC");
   a_fast_dac: assert property (FAST_SETTLE ##1 FAST_SETTLE |=> DAC_LOW_R)
      else $error("Low resistance setting not applied");

   c_out_by4: cover property (OUT_VALID && THIRD_STAGE_SELECT);
   c_out_gain: cover property (OUT_VALID && g_q == DG_SHIFT_MAX);
   c_rssi_full: cover property (RSSI_VALID && RSSI == RSSI_FULL);
endmodule : if_decimator_gain_rssi

`default_nettype wire

// ==== ifdec_pkg.sv ====
// Constants shared by the IF decimator, gain and signal-strength block
package ifdec_pkg;
   localparam int ACC_W = 52;
   localparam int WORD_W = 24;
   localparam int OUT_W = 16;
   localparam int MIX_PHASES = 8;
   localparam logic [3:0] FIRST_DECIMATOR_LAST = 4'hb;
   localparam logic [2:0] THIRD_DECIMATOR_LAST_BY5 = 3'h4;
   localparam logic [2:0] THIRD_DECIMATOR_LAST_BY4 = 3'h3;
   localparam logic [6:0] RATIO_K0 = 7'h3c;
   localparam logic [6:0] RATIO_K1 = 7'h30;
   localparam logic [5:0] RSSI_LAST = 6'h3b;
   localparam logic [5:0] RSSI_FULL = 6'h3c;
   localparam logic [15:0] GAIN_WORD_RST = 16'h0000;
   localparam logic [7:0] DAC_RST = 8'h00;
   localparam logic [1:0] DG_SHIFT_MAX = 2'h2;
   typedef enum logic [0:0] {
      MODE_MANUAL = 1'b0,
      MODE_AUTO = 1'b1
   } gain_mode_t;
   typedef logic signed [ACC_W-1:0] acc_t;
endpackage : ifdec_pkg

// ==== baseband_rx.sv ====
// Baseband receiver model: output cadence, last sample and smoothed strength
`timescale 1ns/1ps
`default_nettype none
module baseband_rx
   import ifdec_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic signed [OUT_W-1:0] i_in,
   input wire logic signed [OUT_W-1:0] q_in,
   input wire logic out_valid,
   input wire logic [5:0] rssi,
   input wire logic rssi_valid,
   output logic [15:0] out_gap,
   output logic [15:0] rssi_gap,
   output logic [15:0] n_samples,
   output logic [OUT_W-1:0] i_last,
   output logic [OUT_W-1:0] q_last,
   output logic [8:0] rssi_avg
);
   logic [15:0] ocnt_q;
   logic [15:0] rcnt_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ocnt_q <= 16'h0000;
         rcnt_q <= 16'h0000;
         out_gap <= 16'h0000;
         rssi_gap <= 16'h0000;
         n_samples <= 16'h0000;
         i_last <= 16'h0000;
         q_last <= 16'h0000;
         rssi_avg <= 9'h000;
      end else begin
         ocnt_q <= out_valid ? 16'h0000 : ocnt_q + 16'h0001;
         rcnt_q <= rssi_valid ? 16'h0000 : rcnt_q + 16'h0001;
         if (out_valid) begin
            out_gap <= ocnt_q + 16'h0001;
            n_samples <= n_samples + 16'h0001;
            i_last <= i_in;
            q_last <= q_in;
         end
         if (rssi_valid) begin
            rssi_gap <= rcnt_q + 16'h0001;
            rssi_avg <= rssi_avg - (rssi_avg >> 3) + {3'h0, rssi};
         end
      end
   end
endmodule : baseband_rx
`default_nettype wire

// ==== tb_if_decimator_gain_rssi.sv ====
// Self-checking bench for the decimator, gain and strength block
`timescale 1ns/1ps
`default_nettype none
module tb_if_decimator_gain_rssi;
   import ifdec_pkg::*;
   logic REF_CLK = 1'b0;
   logic RST = 1'b1;
   logic signed [3:0] ADC_DATA = 4'sh0;
   logic [4:0] SECOND_STAGE_RATIO = 5'h01;
   logic THIRD_STAGE_SELECT = 1'b0;
   logic DIGITAL_GAIN_ENABLE = 1'b0;
   logic [2:0] GAIN_REFERENCE_LEVEL = 3'h0;
   logic [15:0] MANUAL_GAIN_WORD = 16'h0000;
   logic MANUAL_GAIN_WRITE = 1'b0;
   logic FAST_SETTLE = 1'b0;
   logic signed [15:0] I_OUT;
   logic signed [15:0] Q_OUT;
   logic OUT_VALID;
   logic [5:0] RSSI;
   logic [7:0] ATTN;
   logic RSSI_VALID;
   logic [7:0] GAIN_CONTROL_PIN;
   logic DAC_LOW_R;
   logic MIXER_ATTEN;
   logic AUTO_GAIN_ACTIVE;
   logic [15:0] out_gap;
   logic [15:0] rssi_gap;
   logic [15:0] n_samples;
   logic [8:0] rssi_avg;
   logic [15:0] i_last;
   logic [15:0] q_last;
   logic [2:0] ph = 3'h0;
   int errors = 0;
   int n_tests = 0;
   int cycles = 0;
   int k;
   int m;
   logic [15:0] words [3] = '{16'h8fc0, 16'h3fc0, 16'hc5a0};
   logic ens [3] = '{1'b0, 1'b1, 1'b1};
   if_decimator_gain_rssi DUT (.REF_CLK(REF_CLK), .RST(RST), .ADC_DATA(ADC_DATA),
      .SECOND_STAGE_RATIO(SECOND_STAGE_RATIO), .THIRD_STAGE_SELECT(THIRD_STAGE_SELECT),
      .DIGITAL_GAIN_ENABLE(DIGITAL_GAIN_ENABLE), .GAIN_REFERENCE_LEVEL(GAIN_REFERENCE_LEVEL),
      .MANUAL_GAIN_WORD(MANUAL_GAIN_WORD), .MANUAL_GAIN_WRITE(MANUAL_GAIN_WRITE),
      .FAST_SETTLE(FAST_SETTLE), .I_OUT(I_OUT), .Q_OUT(Q_OUT), .OUT_VALID(OUT_VALID),
      .RSSI(RSSI), .ATTN(ATTN), .RSSI_VALID(RSSI_VALID), .GAIN_CONTROL_PIN(GAIN_CONTROL_PIN),
      .DAC_LOW_R(DAC_LOW_R), .MIXER_ATTEN(MIXER_ATTEN), .AUTO_GAIN_ACTIVE(AUTO_GAIN_ACTIVE));
   baseband_rx rx (.clk(REF_CLK), .rst(RST), .i_in(I_OUT), .q_in(Q_OUT),
      .out_valid(OUT_VALID), .rssi(RSSI), .rssi_valid(RSSI_VALID), .out_gap(out_gap),
      .rssi_gap(rssi_gap), .n_samples(n_samples), .i_last(i_last), .q_last(q_last),
      .rssi_avg(rssi_avg));
   always #50 REF_CLK = ~REF_CLK;
   // Eighth-rate test tone, steps on the falling edge
   always @(negedge REF_CLK) begin
      ph <= ph + 3'h1;
      case (ph)
         3'h1, 3'h3: ADC_DATA <= 4'sh5;
         3'h2: ADC_DATA <= 4'sh7;
         3'h5, 3'h7: ADC_DATA <= -4'sh5;
         3'h6: ADC_DATA <= -4'sh7;
         default: ADC_DATA <= 4'sh0;
      endcase
   end
   task automatic conclude();
      $display("errors=%0d n_tests=%0d", errors, n_tests);
      if (errors == 0 && n_tests > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : conclude
   always @(posedge REF_CLK) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         errors = errors + 1;
         $display("mismatch at %0t: run did not finish", $time);
         conclude();
      end
   end
   task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
      n_tests = n_tests + 1;
      if (got !== exp) begin
         errors = errors + 1;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : check
   // Waits for three fresh samples so one irregular period is flushed
   task automatic wait_samples();
      logic [15:0] start;
      start = n_samples;
      for (int i = 0; i < 2000 && n_samples - start < 16'h0003; i++) begin
         @(negedge REF_CLK);
      end
   endtask : wait_samples
   task automatic write_word(input logic [15:0] w);
      MANUAL_GAIN_WORD = w;
      MANUAL_GAIN_WRITE = 1'b1;
      @(negedge REF_CLK);
      MANUAL_GAIN_WRITE = 1'b0;
      @(negedge REF_CLK);
   endtask : write_word
   initial begin
      repeat (12) @(negedge REF_CLK);
      check({GAIN_CONTROL_PIN, ATTN}, 16'h0000, "reset pin and attn");
      check(I_OUT, 16'h0000, "reset I sample");
      check(Q_OUT, 16'h0000, "reset Q sample");
      check({10'h000, OUT_VALID, RSSI_VALID, DAC_LOW_R, MIXER_ATTEN, AUTO_GAIN_ACTIVE, 1'b0},
         16'h0000, "reset flags");
      RST = 1'b0;
      // tone sits at band centre, so every ratio used keeps it in band
      for (k = 0; k < 2; k++) begin
         for (m = 1; m <= 3; m += 2) begin
            THIRD_STAGE_SELECT = k[0];
            SECOND_STAGE_RATIO = m[4:0];
            wait_samples();
            check(out_gap, (k == 0) ? 16'(60 * m) : 16'(48 * m), "output period");
         end
      end
      check(rssi_gap, 16'h003c, "strength period");
      check({15'h0000, RSSI <= RSSI_FULL}, 16'h0001, "strength scale");
      // Tone far below full scale: smoothed strength stays at zero
      check({7'h00, rssi_avg}, 16'h0000, "smoothed strength");
      for (k = 0; k < 3; k++) begin
         DIGITAL_GAIN_ENABLE = ens[k];
         @(negedge REF_CLK);
         write_word(words[k]);
         check({8'h00, ATTN}, {8'h00, words[k][15:8]}, "attn field");
         @(negedge REF_CLK);
         check({15'h0000, MIXER_ATTEN}, {15'h0000, words[k][15]}, "mixer atten");
         check({8'h00, GAIN_CONTROL_PIN},
            (ens[k] && !words[k][14]) ? 16'h0000 : {8'h00, words[k][13:6]},
            "dac code");
         wait_samples();
         // Tone of amplitude 7 lies below one output step: only 0 or -1 may appear
         check({15'h0000, i_last == 16'h0000 || i_last == 16'hffff}, 16'h0001, "I small");
         check({15'h0000, q_last == 16'h0000 || q_last == 16'hffff}, 16'h0001, "Q small");
         // Host gap between gain word rewrites
         repeat (240) @(negedge REF_CLK);
      end
      for (k = 1; k <= 5; k++) begin
         GAIN_REFERENCE_LEVEL = k[2:0];
         @(negedge REF_CLK);
         @(negedge REF_CLK);
         check({15'h0000, AUTO_GAIN_ACTIVE}, 16'h0001, "auto active");
         write_word(16'h1234);
         check({8'h00, ATTN}, {8'h00, words[2][15:8]}, "write ignored");
         repeat (240) @(negedge REF_CLK);
      end
      GAIN_REFERENCE_LEVEL = 3'h0;
      repeat (2) @(negedge REF_CLK);
      check({15'h0000, AUTO_GAIN_ACTIVE}, 16'h0000, "manual again");
      FAST_SETTLE = 1'b1;
      @(negedge REF_CLK);
      check({15'h0000, DAC_LOW_R}, 16'h0001, "low resistance on");
      FAST_SETTLE = 1'b0;
      @(negedge REF_CLK);
      check({15'h0000, DAC_LOW_R}, 16'h0000, "low resistance off");
      conclude();
   end
endmodule : tb_if_decimator_gain_rssi
`default_nettype wire
